// *** inc/opc_pkg.sv ***
// package: register map, field layout, timing and bus carriers
package opc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int OPC_ADDR_W = 12;
    localparam logic [11:0] OPC_CFG_OFS = 12'h060;
    localparam logic [11:0] OPC_XLAT_OFS = 12'h064;
    localparam logic [11:0] OPC_STAT_OFS = 12'h068;

    // ------------------------------------------------------------
    // run clock configuration fields
    // ------------------------------------------------------------
    localparam int OPC_MOSC_OFF_BIT = 0;
    localparam int OPC_INT_OFF_BIT = 1;
    localparam int OPC_MOSC_CHK_BIT = 2;
    localparam int OPC_INT_CHK_BIT = 3;
    localparam int OPC_SRC_LSB = 4;
    localparam int OPC_CRY_LSB = 6;
    localparam int OPC_OE_BIT = 12;
    localparam int OPC_PD_BIT = 13;
    localparam logic [31:0] OPC_CFG_RST = 32'h0000_2000;
    localparam logic [31:0] OPC_CFG_WMASK = 32'h0000_33ff;
    localparam logic [3:0] OPC_CRY_RST = 4'h0;
    localparam logic [1:0] OPC_SRC_MAIN = 2'h0;
    localparam logic [1:0] OPC_SRC_RSVD = 2'h3;

    // ------------------------------------------------------------
    // translation settings
    // ------------------------------------------------------------
    localparam logic [1:0] OPC_DIV_RSVD = 2'h3;
    localparam logic [1:0] OPC_DIV_DEF = 2'h0;
    localparam logic [8:0] OPC_F_DEF = 9'h18e;
    localparam logic [4:0] OPC_R_STEP = 5'h01;

    typedef struct packed {
        logic [1:0] div;
        logic [8:0] f;
        logic [4:0] r;
    } opc_pll_cfg_t;

    function automatic opc_pll_cfg_t opc_translate(input logic [3:0] sel);
        opc_pll_cfg_t c;
        c.div = OPC_DIV_DEF;
        c.f = OPC_F_DEF;
        c.r = {1'b0, sel} + OPC_R_STEP;
        return c;
    endfunction : opc_translate

    // ------------------------------------------------------------
    // verification timing
    // ------------------------------------------------------------
    localparam int OPC_CLK_PERIOD_NS = 25;
    localparam int OPC_VERIFY_TIMEOUT_NS = 10000;
    localparam int OPC_VERIFY_CYC =
        (OPC_VERIFY_TIMEOUT_NS + OPC_CLK_PERIOD_NS - 1) / OPC_CLK_PERIOD_NS;
    localparam logic [8:0] OPC_VERIFY_LAST = 9'(OPC_VERIFY_CYC - 1);

    // ------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------
    localparam logic [1:0] OPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] OPC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } opc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } opc_axi_rsp_t;

endpackage : opc_pkg

// *** rtl/opc_top.sv ***
// oscillator and pll control block with axi4-lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// [R1] int_osc_check_en set runs internal verification timer, fault raised; code runs it only while int_osc_off is 0
// [R2] main_osc_check_en set runs main verification timer, fault raised; code runs it only while main_osc_off is 0
// [R3] int_osc_off 0 runs internal oscillator, 1 stops it; reset 0
// [R4] main_osc_off 0 runs main oscillator, 1 stops it; reset 0
// [R5] pll_power_down 1 powers pll down; both bits 0 is normal
// [R6] translation loaded at reset, reloaded on each crystal_freq_sel change
// [R7] pll frequency is osc times (feedback plus 2) over (ref plus 2)
// [R8] output divider in bits 15:14 driven to pll; code 3 reserved
// [R9] nine-bit feedback multiplier in bits 13:5 driven to pll
// [R10] five-bit reference divider in bits 4:0 driven to pll
// [R11] translation register read-only, bits 31:16 read zero
// [R12] osc_source_sel picks main, internal, internal/4; code 3 reserved
// ----------------------------------------------------------------
module opc_top
    import opc_pkg::*;
(
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // register bus
    input wire opc_axi_req_t I_AXI,
    output opc_axi_rsp_t O_AXI,
    // oscillator monitor inputs, asynchronous
    input wire logic I_MAIN_OSC_MON,
    input wire logic I_INT_OSC_MON,
    // oscillator controls
    output logic O_MAIN_OSC_EN,
    output logic O_INT_OSC_EN,
    output logic [1:0] O_OSC_SOURCE_SEL,
    output logic [1:0] O_OSC_FAULT,
    // pll controls
    output logic O_PLL_POWER_DOWN,
    output logic O_PLL_OUTPUT_EN,
    output logic O_PLL_NORMAL,
    output logic [1:0] O_PLL_OUTPUT_DIVIDER,
    output logic [8:0] O_PLL_FEEDBACK_MULT,
    output logic [4:0] O_PLL_REF_DIVIDER
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    opc_axi_rsp_t rsp_q;
    logic aw_got_q;
    logic w_got_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] cfg_q;
    logic [3:0] cry_prev_q;
    opc_pll_cfg_t xlat_q;
    logic [1:0] fault_q;
    logic [31:0] byte_mask;
    logic [31:0] cfg_wr;
    logic do_wr;
    logic [1:0] mon_raw;
    logic [1:0] chk_en;
    logic [3:0] cry;
    logic [1:0] src;
    logic [31:0] rd_data;
    logic rd_err;

    assign O_AXI = rsp_q;
    assign cry = cfg_q[OPC_CRY_LSB +: 4];
    assign src = cfg_q[OPC_SRC_LSB +: 2];
    assign mon_raw = {I_INT_OSC_MON, I_MAIN_OSC_MON};
    // timer runs only when checking is on and the oscillator is running
    assign chk_en[0] = cfg_q[OPC_MOSC_CHK_BIT]
        & ~cfg_q[OPC_MOSC_OFF_BIT]; // R2
    assign chk_en[1] = cfg_q[OPC_INT_CHK_BIT] & ~cfg_q[OPC_INT_OFF_BIT]; // R1

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    assign do_wr = aw_got_q & w_got_q & ~rsp_q.bvalid;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            rsp_q.awready <= 1'b1;
            rsp_q.wready <= 1'b1;
            rsp_q.bvalid <= 1'b0;
            rsp_q.bresp <= OPC_RESP_OKAY;
        end else begin
            if (rsp_q.awready && I_AXI.awvalid) begin
                aw_got_q <= 1'b1;
                awaddr_q <= I_AXI.awaddr;
                rsp_q.awready <= 1'b0;
            end
            if (rsp_q.wready && I_AXI.wvalid) begin
                w_got_q <= 1'b1;
                wdata_q <= I_AXI.wdata;
                wstrb_q <= I_AXI.wstrb;
                rsp_q.wready <= 1'b0;
            end
            if (do_wr) begin
                rsp_q.bvalid <= 1'b1;
                if (awaddr_q == OPC_CFG_OFS || awaddr_q == OPC_XLAT_OFS ||
                    awaddr_q == OPC_STAT_OFS) begin
                    rsp_q.bresp <= OPC_RESP_OKAY;
                end else begin
                    rsp_q.bresp <= OPC_RESP_SLVERR;
                end
            end
            if (rsp_q.bvalid && I_AXI.bready) begin
                rsp_q.bvalid <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                rsp_q.awready <= 1'b1;
                rsp_q.wready <= 1'b1;
            end
        end
    end

    // byte lanes of the write strobe
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign byte_mask[gb*8 +: 8] = {8{wstrb_q[gb]}};
        end
    endgenerate

    assign cfg_wr = ((wdata_q & byte_mask) | (cfg_q & ~byte_mask))
        & OPC_CFG_WMASK;

    // ------------------------------------------------------------
    // run clock configuration
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            cfg_q <= OPC_CFG_RST; // R3 R4
        end else if (do_wr && awaddr_q == OPC_CFG_OFS) begin
            cfg_q <= cfg_wr;
        end
    end

    // ------------------------------------------------------------
    // translation register
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            cry_prev_q <= OPC_CRY_RST;
            xlat_q <= opc_translate(OPC_CRY_RST); // R6
        end else begin
            cry_prev_q <= cry;
            if (cry != cry_prev_q) begin
                xlat_q <= opc_translate(cry); // R6
            end
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        case (I_AXI.araddr)
            OPC_CFG_OFS: rd_data = cfg_q;
            OPC_XLAT_OFS: rd_data = {16'h0000, xlat_q}; // R11
            OPC_STAT_OFS: rd_data = {30'h0, fault_q};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            rsp_q.arready <= 1'b1;
            rsp_q.rvalid <= 1'b0;
            rsp_q.rdata <= '0;
            rsp_q.rresp <= OPC_RESP_OKAY;
        end else if (rsp_q.arready && I_AXI.arvalid) begin
            rsp_q.arready <= 1'b0;
            rsp_q.rvalid <= 1'b1;
            rsp_q.rdata <= rd_data;
            rsp_q.rresp <= rd_err ? OPC_RESP_SLVERR : OPC_RESP_OKAY;
        end else if (rsp_q.rvalid && I_AXI.rready) begin
            rsp_q.rvalid <= 1'b0;
            rsp_q.arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // oscillator verification timers, 0 main, 1 internal
    // ------------------------------------------------------------
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_verify
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic [8:0] cnt_q;
            logic edge_seen;

            assign edge_seen = s2_q ^ s3_q;

            always_ff @(posedge I_CLOCK) begin
                if (!I_RST_N) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= mon_raw[gc];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            always_ff @(posedge I_CLOCK) begin
                if (!I_RST_N) begin
                    cnt_q <= '0;
                    fault_q[gc] <= 1'b0;
                end else if (!chk_en[gc] || edge_seen) begin
                    cnt_q <= '0; // R1 R2
                end else if (cnt_q == OPC_VERIFY_LAST) begin
                    fault_q[gc] <= 1'b1; // R1 R2
                end else begin
                    cnt_q <= cnt_q + 9'h001;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // registered control outputs
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_MAIN_OSC_EN <= 1'b1;
            O_INT_OSC_EN <= 1'b1;
            O_OSC_SOURCE_SEL <= OPC_SRC_MAIN;
            O_OSC_FAULT <= 2'h0;
        end else begin
            O_MAIN_OSC_EN <= ~cfg_q[OPC_MOSC_OFF_BIT]; // R4
            O_INT_OSC_EN <= ~cfg_q[OPC_INT_OFF_BIT]; // R3
            O_OSC_FAULT <= fault_q; // R1 R2
            // reserved source code falls back to the main oscillator
            if (src == OPC_SRC_RSVD) begin
                O_OSC_SOURCE_SEL <= OPC_SRC_MAIN; // R12
            end else begin
                O_OSC_SOURCE_SEL <= src; // R12
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_PLL_POWER_DOWN <= 1'b1;
            O_PLL_OUTPUT_EN <= 1'b0;
            O_PLL_NORMAL <= 1'b0;
        end else begin
            O_PLL_POWER_DOWN <= cfg_q[OPC_PD_BIT]; // R5
            O_PLL_OUTPUT_EN <= cfg_q[OPC_OE_BIT]; // R5
            O_PLL_NORMAL <= ~cfg_q[OPC_PD_BIT] & ~cfg_q[OPC_OE_BIT]; // R5
        end
    end

    // settings that fix the pll ratio (f + 2) / (r + 2)
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_PLL_OUTPUT_DIVIDER <= OPC_DIV_DEF;
            O_PLL_FEEDBACK_MULT <= OPC_F_DEF;
            O_PLL_REF_DIVIDER <= '0;
        end else begin
            O_PLL_OUTPUT_DIVIDER <= xlat_q.div; // R8 R7
            O_PLL_FEEDBACK_MULT <= xlat_q.f; // R9 R7
            O_PLL_REF_DIVIDER <= xlat_q.r; // R10 R7
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_N);

    property p_int_timeout;
        chk_en[1] && !g_verify[1].edge_seen &&
            g_verify[1].cnt_q == OPC_VERIFY_LAST |=> ##1 O_OSC_FAULT[1];
    endproperty
    a_int_timeout: assert property (p_int_timeout) // R1
        else $error("internal fault not raised at timeout");

    property p_main_timeout;
        chk_en[0] && !g_verify[0].edge_seen &&
            g_verify[0].cnt_q == OPC_VERIFY_LAST |=> ##1 O_OSC_FAULT[0];
    endproperty
    a_main_timeout: assert property (p_main_timeout) // R2
        else $error("main fault not raised at timeout");

    property p_fault_needs_check;
        $rose(fault_q[0]) |-> $past(chk_en[0]);
    endproperty
    a_fault_needs_check: assert property (p_fault_needs_check) // R2
        else $error("main fault raised with checking off");

    property p_int_osc_en;
        $fell(cfg_q[OPC_INT_OFF_BIT]) |=> O_INT_OSC_EN;
    endproperty
    a_int_osc_en: assert property (p_int_osc_en) // R3
        else $error("internal oscillator not enabled");

    property p_main_osc_off;
        cfg_q[OPC_MOSC_OFF_BIT] [*2] |-> !O_MAIN_OSC_EN;
    endproperty
    a_main_osc_off: assert property (p_main_osc_off) // R4
        else $error("main oscillator not stopped");

    property p_pll_mode;
        O_PLL_POWER_DOWN |-> !O_PLL_NORMAL;
    endproperty
    a_pll_mode: assert property (p_pll_mode) // R5
        else $error("pll normal while powered down");

    property p_xlat_update;
        cry != cry_prev_q |=> xlat_q == opc_translate($past(cry));
    endproperty
    a_xlat_update: assert property (p_xlat_update) // R6
        else $error("translation not reloaded on crystal change");

    property p_od_valid;
        1'b1 |=> O_PLL_OUTPUT_DIVIDER == $past(xlat_q.div)
            && O_PLL_OUTPUT_DIVIDER != OPC_DIV_RSVD;
    endproperty
    a_od_valid: assert property (p_od_valid) // R8
        else $error("reserved output divider code");

    property p_fb_drive;
        1'b1 |=> O_PLL_FEEDBACK_MULT == $past(xlat_q.f)
            && O_PLL_REF_DIVIDER == $past(xlat_q.r);
    endproperty
    a_fb_drive: assert property (p_fb_drive) // R9 R10
        else $error("pll settings differ from translation");

    property p_xlat_read;
        rsp_q.arready && I_AXI.arvalid && I_AXI.araddr == OPC_XLAT_OFS
            |=> rsp_q.rvalid && rsp_q.rdata[31:16] == 16'h0000;
    endproperty
    a_xlat_read: assert property (p_xlat_read) // R11
        else $error("translation read upper bits not zero");

    property p_src_valid;
        O_OSC_SOURCE_SEL != OPC_SRC_RSVD;
    endproperty
    a_src_valid: assert property (p_src_valid) // R12
        else $error("reserved oscillator source driven");

    c_write: cover property (rsp_q.bvalid && I_AXI.bready);
    c_read: cover property (rsp_q.rvalid && I_AXI.rready);
    c_fault: cover property ($rose(O_OSC_FAULT[1]));
    c_crystal: cover property (cry != cry_prev_q);

endmodule : opc_top

// *** verification/opc_testbench.sv ***
// self-checking testbench for the oscillator and pll control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module testbench;
    import opc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    opc_axi_req_t req = '0;
    opc_axi_rsp_t rsp;
    logic main_mon = 1'b0;
    logic int_mon = 1'b0;
    logic main_run = 1'b1;
    logic int_run = 1'b1;
    logic main_en, int_en, pd, pll_oe, normal;
    logic [1:0] src;
    logic [1:0] fault;
    logic [1:0] pdiv;
    logic [8:0] fb;
    logic [4:0] rdiv;
    int fail_count = 0;
    int checks = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    // oscillator monitors toggle while running, freeze when stopped
    always @(posedge clk) begin
        if (main_run) main_mon <= ~main_mon;
        if (int_run) int_mon <= ~int_mon;
    end

    opc_top opc_top_inst (
        .I_CLOCK(clk),
        .I_RST_N(rst_n),
        .I_AXI(req),
        .O_AXI(rsp),
        .I_MAIN_OSC_MON(main_mon),
        .I_INT_OSC_MON(int_mon),
        .O_MAIN_OSC_EN(main_en),
        .O_INT_OSC_EN(int_en),
        .O_OSC_SOURCE_SEL(src),
        .O_OSC_FAULT(fault),
        .O_PLL_POWER_DOWN(pd),
        .O_PLL_OUTPUT_EN(pll_oe),
        .O_PLL_NORMAL(normal),
        .O_PLL_OUTPUT_DIVIDER(pdiv),
        .O_PLL_FEEDBACK_MULT(fb),
        .O_PLL_REF_DIVIDER(rdiv)
    );

    // ------------------------------------------------------------
    // expectations and bus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xlat_exp(input logic [3:0] s);
        logic [4:0] r;
        r = {1'b0, s} + 5'h01;
        return {16'h0000, 2'h0, 9'h18e, r};
    endfunction : xlat_exp

    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] resp);
        int n;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                resp = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
        if (n == 100) begin fail_count++; test_done(); end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        int n;
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                d = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
        if (n == 100) begin fail_count++; test_done(); end
    endtask : rd

    task automatic wait_fault(input int b, output int n);
        for (n = 0; n < 600; n++) begin
            @(posedge clk);
            if (fault[b] === 1'b1) break;
        end
        if (n == 600) begin fail_count++; test_done(); end
    endtask : wait_fault

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d, r, keep;
        logic [1:0] resp;
        logic [1:0] s;
        int n;
        void'($urandom(49231));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wait_cyc(3);
        `CHK(main_en, 1'b1)
        `CHK(int_en, 1'b1)
        `CHK(pd, 1'b1)
        `CHK(normal, 1'b0)
        `CHK(fb, 9'h18e)
        rd(OPC_CFG_OFS, r, resp);
        `CHK(r, 32'h0000_2000)
        rd(OPC_XLAT_OFS, r, resp);
        `CHK(r, xlat_exp(4'h0))
        // every crystal code, source code and pll mode, rest random
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            d[9:6] = 4'(i);
            d[5:4] = 2'(i);
            d[13:12] = 2'(i) ^ 2'(i >> 2);
            wr(OPC_CFG_OFS, d, 4'hf, resp);
            `CHK(resp, 2'h0)
            wait_cyc(3);
            `CHK(main_en, ~d[0])
            `CHK(int_en, ~d[1])
            `CHK(pd, d[13])
            `CHK(pll_oe, d[12])
            `CHK(normal, ~d[13] & ~d[12])
            s = d[5:4];
            `CHK(src, (s == 2'h3) ? 2'h0 : s)
            `CHK(pdiv, 2'h0)
            `CHK(fb, xlat_exp(d[9:6]) >> 5)
            `CHK(rdiv, xlat_exp(d[9:6]) & 32'h1f)
            rd(OPC_CFG_OFS, r, resp);
            `CHK(r, d & 32'h0000_33ff)
            rd(OPC_XLAT_OFS, r, resp);
            `CHK(r, xlat_exp(d[9:6]))
        end
        keep = d & 32'h0000_3300;
        wr(OPC_CFG_OFS, 32'h0000_0000, 4'h1, resp);
        rd(OPC_CFG_OFS, r, resp);
        `CHK(r, keep)
        // crystal field now holds the upper byte lane bits kept above
        wr(OPC_XLAT_OFS, 32'hffff_ffff, 4'hf, resp);
        rd(OPC_XLAT_OFS, r, resp);
        `CHK(r, xlat_exp(keep[9:6]))
        wr(12'h100, 32'hffff_ffff, 4'hf, resp);
        `CHK(resp, 2'h2)
        rd(12'hffc, r, resp);
        `CHK(resp, 2'h2)
        rd(OPC_CFG_OFS, r, resp);
        `CHK(r, keep)
        // verification timers: off, then main dies, then internal dies
        wr(OPC_CFG_OFS, 32'h0000_2000, 4'hf, resp);
        main_run <= 1'b0;
        int_run <= 1'b0;
        wait_cyc(500);
        `CHK(fault, 2'h0)
        int_run <= 1'b1;
        wait_cyc(10);
        wr(OPC_CFG_OFS, 32'h0000_200c, 4'hf, resp);
        wait_fault(0, n);
        `CHK(n >= 395 && n <= 420, 1'b1)
        `CHK(fault[1], 1'b0)
        rd(OPC_STAT_OFS, r, resp);
        `CHK(r, 32'h0000_0001)
        int_run <= 1'b0;
        wait_fault(1, n);
        `CHK(n >= 395 && n <= 425, 1'b1)
        main_run <= 1'b1;
        wait_cyc(20);
        `CHK(fault, 2'h3)
        test_done();
    end
endmodule : testbench
